// ---- design/sbw_adder.sv ----
`default_nettype none

module sbw_adder
    import sbw_pkg::*;
#(
    parameter int unsigned WIDTH = DATA_W
)
(
    // Operands.
    input  wire logic [WIDTH-1:0] add_a,
    input  wire logic [WIDTH-1:0] add_b,
    input  wire logic             add_cin,
    // Results.
    output logic      [WIDTH-1:0] add_sum,
    output logic                  add_cout,
    output logic                  add_nibble_cout
);

    logic [WIDTH:0]        full_sum;
    logic [NIBBLE_BIT+1:0] low_sum;

    // The full sum forms the result and the borrow-not flag.
    assign full_sum = {1'b0, add_a} + {1'b0, add_b} + {{WIDTH{1'b0}}, add_cin};
    assign add_sum  = full_sum[WIDTH-1:0];
    assign add_cout = full_sum[WIDTH];

    // The low nibble of the same addition gives the nibble carry.
    assign low_sum = {1'b0, add_a[NIBBLE_BIT:0]} + {1'b0, add_b[NIBBLE_BIT:0]}
                   + {{(NIBBLE_BIT+1){1'b0}}, add_cin};
    assign add_nibble_cout = low_sum[NIBBLE_BIT+1];

endmodule : sbw_adder

`default_nettype wire

// ---- design/sbw_alu.sv ----
`default_nettype none

module sbw_alu
    import sbw_pkg::*;
(
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Operation requests from the decoder.
    input  wire logic              sub_borrow_reg_op,
    input  wire logic              sub_borrow_imm_op,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              result_target_bit,
    input  wire logic [DATA_W-1:0] reg_rd_data,
    input  wire logic [DATA_W-1:0] imm_data,
    // Loads from other instructions of the core.
    input  wire logic              work_load,
    input  wire logic [DATA_W-1:0] work_load_data,
    input  wire logic              flags_load,
    input  wire logic [2:0]        flags_load_data,
    // Architectural state.
    output logic      [DATA_W-1:0] working_register,
    output logic                   null_result_flag,
    output logic                   nibble_carry,
    output logic                   borrow_not_bit,
    // Data memory write-back.
    output logic                   mem_wr_en,
    output logic      [ADDR_W-1:0] mem_wr_addr,
    output logic      [DATA_W-1:0] mem_wr_data
);

    logic [DATA_W-1:0] work_reg;
    logic [DATA_W-1:0] work_next;
    logic              null_reg;
    logic              nibble_reg;
    logic              borrow_reg;
    logic              mem_en_reg;
    logic [ADDR_W-1:0] mem_addr_reg;
    logic [DATA_W-1:0] mem_data_reg;
    logic              any_op;
    logic              to_mem;
    logic [DATA_W-1:0] operand_a;
    logic [DATA_W-1:0] sum;
    logic              sum_cout;
    logic              sum_nibble;

    // The register operation wins if both requests arrive together.
    assign any_op    = sub_borrow_reg_op | sub_borrow_imm_op;
    assign operand_a = sub_borrow_reg_op ? reg_rd_data : imm_data;
    assign to_mem    = sub_borrow_reg_op & (result_target_bit == TARGET_MEM);

    // Adding the inverted working register with borrow-not as carry in subtracts.
    sbw_adder #(
        .WIDTH           (DATA_W)
    ) u_adder (
        .add_a           (operand_a),
        .add_b           (~work_reg),
        .add_cin         (borrow_reg),
        .add_sum         (sum),
        .add_cout        (sum_cout),
        .add_nibble_cout (sum_nibble)
    );

    // Next working register value; an operation outranks a core load.
    always_comb
    begin
        work_next = work_reg;
        if (any_op && !to_mem)
        begin
            work_next = sum;
        end
        else if (!any_op && work_load)
        begin
            work_next = work_load_data;
        end
    end

    // Working register.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            work_reg <= WORK_RESET;
        end
        else
        begin
            work_reg <= work_next;
        end
    end

    // Status flags.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            null_reg   <= NULL_RESET;
            nibble_reg <= NIBBLE_RESET;
            borrow_reg <= BORROW_RESET;
        end
        else if (any_op)
        begin
            null_reg   <= (sum == {DATA_W{1'b0}});
            nibble_reg <= sum_nibble;
            borrow_reg <= sum_cout;
        end
        else if (flags_load)
        begin
            null_reg   <= flags_load_data[2];
            nibble_reg <= flags_load_data[1];
            borrow_reg <= flags_load_data[0];
        end
    end

    // Data memory write-back, one pulse per register operation that targets data memory.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mem_en_reg   <= 1'b0;
            mem_addr_reg <= MEM_ADDR_RESET;
            mem_data_reg <= MEM_DATA_RESET;
        end
        else
        begin
            mem_en_reg <= to_mem;
            if (to_mem)
            begin
                mem_addr_reg <= reg_addr;
                mem_data_reg <= sum;
            end
        end
    end

    assign working_register = work_reg;
    assign null_result_flag = null_reg;
    assign nibble_carry     = nibble_reg;
    assign borrow_not_bit   = borrow_reg;
    assign mem_wr_en        = mem_en_reg;
    assign mem_wr_addr      = mem_addr_reg;
    assign mem_wr_data      = mem_data_reg;

    // Reference sums for the checks below.
    logic [DATA_W:0]       chk_reg_sum;
    logic [DATA_W:0]       chk_imm_sum;
    logic [NIBBLE_BIT+1:0] chk_low_sum;

    assign chk_reg_sum = {1'b0, reg_rd_data} + {1'b0, ~work_reg}
                       + {{DATA_W{1'b0}}, borrow_reg};
    assign chk_imm_sum = {1'b0, imm_data} + {1'b0, ~work_reg}
                       + {{DATA_W{1'b0}}, borrow_reg};
    assign chk_low_sum = {1'b0, operand_a[NIBBLE_BIT:0]} + {1'b0, ~work_reg[NIBBLE_BIT:0]}
                       + {{(NIBBLE_BIT+1){1'b0}}, borrow_reg};

    AST_REG_SUM_WORK: assert property (@(posedge clk) disable iff (!rst_n)
        (sub_borrow_reg_op && result_target_bit == TARGET_WORK)
        |=> (working_register == $past(chk_reg_sum[DATA_W-1:0])) && !mem_wr_en)
        else $error("register op result in working register is wrong");

    AST_REG_TO_MEM: assert property (@(posedge clk) disable iff (!rst_n)
        (sub_borrow_reg_op && result_target_bit == TARGET_MEM)
        |=> mem_wr_en && (mem_wr_addr == $past(reg_addr))
            && (mem_wr_data == $past(chk_reg_sum[DATA_W-1:0]))
            && $stable(working_register))
        else $error("register op write-back to data memory is wrong");

    AST_IMM_SUM: assert property (@(posedge clk) disable iff (!rst_n)
        (sub_borrow_imm_op && !sub_borrow_reg_op)
        |=> working_register == $past(chk_imm_sum[DATA_W-1:0]))
        else $error("immediate op result is wrong");

    AST_IMM_NO_MEM: assert property (@(posedge clk) disable iff (!rst_n)
        (sub_borrow_imm_op && !sub_borrow_reg_op) |=> !mem_wr_en)
        else $error("immediate op wrote data memory");

    AST_BORROW_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
        sub_borrow_reg_op
        |=> borrow_not_bit == $past(chk_reg_sum[DATA_W]))
        else $error("borrow-not flag does not match the sum");

    AST_NULL_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
        (sub_borrow_imm_op && !sub_borrow_reg_op)
        |=> null_result_flag == (working_register == {DATA_W{1'b0}}))
        else $error("zero flag does not match the result");

    AST_NIBBLE_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
        any_op |=> nibble_carry == $past(chk_low_sum[NIBBLE_BIT+1]))
        else $error("nibble carry is not the bit 3 carry");

    AST_ONE_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
        mem_wr_en |-> $past(to_mem))
        else $error("data memory write not caused by the previous cycle");

    AST_REG_NULL_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
        sub_borrow_reg_op
        |=> null_result_flag == ($past(chk_reg_sum[DATA_W-1:0]) == {DATA_W{1'b0}}))
        else $error("zero flag does not match the register op result");

    AST_IMM_BORROW_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
        (sub_borrow_imm_op && !sub_borrow_reg_op)
        |=> borrow_not_bit == $past(chk_imm_sum[DATA_W]))
        else $error("borrow-not flag does not match the immediate sum");

    AST_IMM_IGNORES_TARGET: assert property (@(posedge clk) disable iff (!rst_n)
        (sub_borrow_imm_op && !sub_borrow_reg_op && result_target_bit == TARGET_MEM)
        |=> !mem_wr_en && (working_register == $past(chk_imm_sum[DATA_W-1:0])))
        else $error("immediate op followed the destination select");

    AST_REG_OVER_IMM: assert property (@(posedge clk) disable iff (!rst_n)
        (sub_borrow_reg_op && sub_borrow_imm_op && result_target_bit == TARGET_WORK)
        |=> working_register == $past(chk_reg_sum[DATA_W-1:0]))
        else $error("register op did not win over the immediate op");

endmodule : sbw_alu

`default_nettype wire

// ---- design/sbw_pkg.sv ----
`default_nettype none

package sbw_pkg;

    // Operand and address widths.
    localparam int unsigned DATA_W         = 8;
    localparam int unsigned ADDR_W         = 6;
    localparam logic [5:0]  REG_ADDR_MAX   = 6'h3f;

    // Carry out of this bit of the sum is the nibble carry.
    localparam int unsigned NIBBLE_BIT     = 3;

    // Values after reset.
    localparam logic [7:0]  WORK_RESET     = 8'h00;
    localparam logic        NULL_RESET     = 1'b0;
    localparam logic        NIBBLE_RESET   = 1'b0;
    localparam logic        BORROW_RESET   = 1'b0;
    localparam logic [7:0]  MEM_DATA_RESET = 8'h00;
    localparam logic [5:0]  MEM_ADDR_RESET = 6'h00;

    // Destination select values.
    localparam logic        TARGET_WORK    = 1'b0;
    localparam logic        TARGET_MEM     = 1'b1;

    // Cycles from an accepted operation to its visible result.
    localparam int unsigned OP_CYCLES      = 1;

endpackage : sbw_pkg

`default_nettype wire

// ---- test/sbw_regfile.sv ----
`default_nettype none

module sbw_regfile
(
    // Read side.
    input  wire logic       sel,
    input  wire logic [5:0] addr,
    output logic      [7:0] rd_data,
    // Write side.
    input  wire logic       clk,
    input  wire logic       wr_en,
    input  wire logic [5:0] wr_addr,
    input  wire logic [7:0] wr_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [64];
    // An unselected read shows the inverted byte.
    assign rd_data = sel ? mem[addr] : ~mem[addr];
    always @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end
endmodule : sbw_regfile

`default_nettype wire

// ---- test/test_subtract_with_borrow_alu.sv ----
`default_nettype none

module test_subtract_with_borrow_alu;
    import sbw_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk, rst_n, rop, iop, tgt, wl, fl, z, nc, c, mwe;
    logic [5:0] addr, mwa;
    logic [7:0] rdd, imm, wld, wr, mwd, ew;
    logic [2:0] fld;
    logic       ec;
    int         bad_count = 0;
    int         comparisons = 0;
    sbw_alu dut (.clk(clk), .rst_n(rst_n), .sub_borrow_reg_op(rop), .sub_borrow_imm_op(iop),
        .reg_addr(addr), .result_target_bit(tgt), .reg_rd_data(rdd), .imm_data(imm),
        .work_load(wl), .work_load_data(wld), .flags_load(fl), .flags_load_data(fld),
        .working_register(wr), .null_result_flag(z), .nibble_carry(nc),
        .borrow_not_bit(c), .mem_wr_en(mwe), .mem_wr_addr(mwa), .mem_wr_data(mwd));
    sbw_regfile rf (.sel(rop), .addr(addr), .rd_data(rdd), .clk(clk), .wr_en(mwe),
        .wr_addr(mwa), .wr_data(mwd));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    // Requests stay raised on return; the next call or idle changes them once.
    task automatic load(input logic [7:0] w, input logic cin);
        rop = 1'b0;
        iop = 1'b0;
        wl = 1'b1;
        wld = w;
        fl = 1'b1;
        fld = {2'b00, cin};
        @(posedge clk);
        #1;
        ew = w;
        ec = cin;
    endtask : load
    task automatic idle();
        rop = 1'b0;
        iop = 1'b0;
        wl = 1'b0;
        fl = 1'b0;
        @(posedge clk);
        #1;
    endtask : idle
    // Imm op and both loads are raised too: with r set the register op must win over all of them, with r clear the imm op over the loads.
    task automatic op(input logic r, input logic t, input logic [5:0] a, input logic [7:0] v);
        logic [8:0] s;
        logic [4:0] n;
        s = {1'b0, v} + {1'b0, ~ew} + 9'(ec);
        n = {1'b0, v[3:0]} + {1'b0, ~ew[3:0]} + 5'(ec);
        if (r)
            rf.mem[a] = v;
        rop = r;
        iop = 1'b1;
        tgt = t;
        addr = a;
        imm = r ? ~v : v;
        wl = 1'b1;
        wld = ~v;
        fl = 1'b1;
        fld = 3'h7;
        @(posedge clk);
        #1;
        check("borrow_not_bit", c, s[8]);
        check("null_result_flag", z, s[7:0] == 8'h00);
        check("nibble_carry", nc, n[4]);
        check("mem_wr_en", mwe, r & t);
        check("working_register", wr, (r & t) ? ew : s[7:0]);
        if (r & t)
            check("mem_wr_data", mwd, s[7:0]);
        if (r & t)
            check("mem_wr_addr", mwa, a);
        if (!(r & t))
            ew = s[7:0];
        ec = s[8];
    endtask : op
    task automatic test_reg_mem();
        for (int i = 0; i < 4; i++)
        begin
            load(i < 2 ? 8'h06 : 8'h05, i[0]);
            op(1'b1, 1'b1, 6'(i * 21), i < 2 ? 8'h05 : 8'h06);
        end
        idle();
        check("mem_wr_en idle", mwe, 1'b0);
        check("data register", rf.mem[63], 8'h01);
        $display("test_reg_mem done");
    endtask : test_reg_mem
    task automatic test_reg_work();
        load(8'h3c, 1'b1);
        for (int i = 0; i < 8; i++)
            op(1'b1, 1'b0, 6'(i * 9), 8'(i * 37));
        $display("test_reg_work done");
    endtask : test_reg_work
    task automatic test_imm();
        for (int i = 0; i < 4; i++)
        begin
            load(i < 2 ? 8'h06 : 8'h05, i[0]);
            op(1'b0, 1'b1, 6'h00, i < 2 ? 8'h05 : 8'h06);
        end
        for (int i = 0; i < 8; i++)
            op(1'b0, 1'b1, 6'h3f, 8'(i * 73 + 8));
        $display("test_imm done");
    endtask : test_imm
    // Reset in mid-run with every request raised; the first op then uses reset state.
    task automatic test_reset();
        rst_n = 1'b0;
        rop = 1'b1;
        tgt = 1'b1;
        addr = 6'h15;
        repeat (2) @(posedge clk);
        #1;
        check("mem_wr_en in reset", mwe, 1'b0);
        check("mem_wr_addr in reset", mwa, MEM_ADDR_RESET);
        check("mem_wr_data in reset", mwd, MEM_DATA_RESET);
        check("working_register in reset", wr, WORK_RESET);
        check("borrow_not_bit in reset", c, BORROW_RESET);
        check("null_result_flag in reset", z, NULL_RESET);
        check("nibble_carry in reset", nc, NIBBLE_RESET);
        rst_n = 1'b1;
        idle();
        ew = WORK_RESET;
        ec = BORROW_RESET;
        op(1'b1, 1'b0, 6'h15, 8'h5a);
        op(1'b0, 1'b0, 6'h00, 8'h00);
        idle();
        $display("test_reset done");
    endtask : test_reset
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #20000;
        bad_count++;
        conclude();
    end
    initial
    begin
        rst_n = 1'b0;
        {rop, iop, tgt, wl, fl, addr, imm, wld, fld} = '0;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        @(posedge clk);
        #1;
        test_reg_mem();
        test_reg_work();
        test_imm();
        test_reset();
        conclude();
    end
endmodule : test_subtract_with_borrow_alu

`default_nettype wire
